//--- design/ephp_port.v
// edge pulse handshake parallel port with axi4-lite register access
//
// Decided for this implementation: the register addresses and register access over AXI4-Lite.
`timescale 1ns/1ps
`include "ephp_consts.vh"
//
// Overview of operation
// - trailing-edge input with request latching captures the word on the request trailing edge.
// - with request latching off, input is sampled at the acknowledge assertion edge.
// - trailing-edge output without request latching holds the word a minimum time after request ends.
// - trailing-edge output with request latching may change the word right after request ends.
// - leading-edge input starts with acknowledge off and waits for an active request first.
// - leading-edge input issues one acknowledge pulse each time the port can take a word.
// - in leading-edge mode the acknowledge pulse has a fixed width when request is already inactive.
// - in leading-edge mode acknowledge stays asserted while request is still active at the end of the pulse.
// - a programmable delay precedes every acknowledge assertion to throttle transfers.
// - trailing-edge input signals readiness with an acknowledge pulse of programmable width.
// - in leading-edge mode the rising edge of the partner pulse marks readiness.
module ephp_port #(
  parameter DW = 32
) (
  input  wire          aclk,
  input  wire          aresetn,
  input  wire [7:0]    s_axi_awaddr,
  input  wire          s_axi_awvalid,
  output reg           s_axi_awready,
  input  wire [31:0]   s_axi_wdata,
  input  wire [3:0]    s_axi_wstrb,
  input  wire          s_axi_wvalid,
  output reg           s_axi_wready,
  output reg  [1:0]    s_axi_bresp,
  output reg           s_axi_bvalid,
  input  wire          s_axi_bready,
  input  wire [7:0]    s_axi_araddr,
  input  wire          s_axi_arvalid,
  output reg           s_axi_arready,
  output reg  [31:0]   s_axi_rdata,
  output reg  [1:0]    s_axi_rresp,
  output reg           s_axi_rvalid,
  input  wire          s_axi_rready,
  input  wire          req_in,
  input  wire [DW-1:0] data_in,
  output reg           ack_out,
  output reg  [DW-1:0] data_out,
  output reg           data_oe
);

  localparam [2:0] S_IDLE  = 3'h0;
  localparam [2:0] S_DELAY = 3'h1;
  localparam [2:0] S_ACK   = 3'h2;
  localparam [2:0] S_WAIT  = 3'h3;
  localparam [2:0] S_HOLD  = 3'h4;

  localparam [15:0] LEAD_W_CYC = `EPHP_CEIL_CYC(`EPHP_TAA_LEAD_NS);
  localparam [15:0] HOLD_CYC   = `EPHP_CEIL_CYC(`EPHP_TRDO_NS);
  localparam [2:0]  SEL_NONE   = 3'h7;

  // register index from a byte address, SEL_NONE when unmapped
  function [2:0] reg_sel;
    input [7:0] addr;
    begin
      case (addr)
        `EPHP_CTRL_OFF:  reg_sel = 3'h0;
        `EPHP_ACKW_OFF:  reg_sel = 3'h1;
        `EPHP_DELAY_OFF: reg_sel = 3'h2;
        `EPHP_OUT_OFF:   reg_sel = 3'h3;
        `EPHP_IN_OFF:    reg_sel = 3'h4;
        `EPHP_STAT_OFF:  reg_sel = 3'h5;
        default:         reg_sel = SEL_NONE;
      endcase
    end
  endfunction

  // byte-lane merge of a write into a stored word
  function [31:0] wmerge;
    input [31:0] old;
    input [31:0] nw;
    input [3:0]  strb;
    integer i;
    begin
      wmerge = old;
      for (i = 0; i < 4; i = i + 1) begin
        if (strb[i])
          wmerge[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
  endfunction

  reg  [6:0]    ctrl_q;
  reg  [7:0]    ackw_q;
  reg  [15:0]   delay_q;
  reg  [31:0]   out_word_q;
  reg  [31:0]   in_word_q;
  reg           in_valid_q;
  reg           out_pend_q;
  reg  [7:0]    aw_addr_q;
  reg  [31:0]   w_data_q;
  reg  [3:0]    w_strb_q;
  reg           aw_have_q;
  reg           w_have_q;

  reg           req_s1_q;
  reg           req_s2_q;
  reg           req_s3_q;
  reg  [DW-1:0] data_s1_q;
  reg  [DW-1:0] data_s2_q;
  reg  [2:0]    st_q;
  reg  [15:0]   cnt_q;
  reg           seen_q;
  reg           pend_q;
  reg           got_q;

  wire en       = ctrl_q[`EPHP_CTRL_EN];
  wire dir_out  = ctrl_q[`EPHP_CTRL_DIR];
  wire lead     = ctrl_q[`EPHP_CTRL_LEAD];
  wire latch_in = ctrl_q[`EPHP_CTRL_LATIN];
  wire latch_o  = ctrl_q[`EPHP_CTRL_LATOUT];
  wire req_pol  = ctrl_q[`EPHP_CTRL_REQPOL];
  wire ack_pol  = ctrl_q[`EPHP_CTRL_ACKPOL];

  // edge detection only looks at the second and third stages
  wire req_act  = req_s2_q ~^ req_pol;
  wire req_was  = req_s3_q ~^ req_pol;
  wire req_rise = req_act & ~req_was;
  wire req_fall = ~req_act & req_was;
  wire req_ev   = lead ? req_rise : req_fall;

  wire ready    = dir_out ? out_pend_q : ~in_valid_q;
  // no input transfer starts before the peripheral has shown itself once; output transfers do not wait for it
  wire go       = en & ready & (dir_out | seen_q);
  wire dly_done = (st_q == S_DELAY) && (cnt_q == 16'h0000);
  // a request edge can land while acknowledge is still held, so both states take it
  wire take_ev  = ((st_q == S_ACK) | (st_q == S_WAIT)) & req_ev & ~got_q;
  wire cap_lat  = take_ev & ~dir_out & latch_in;
  wire pend_set = ~dir_out & ~latch_in;
  wire [2:0] st_after = (dir_out && !latch_o) ? S_HOLD : S_IDLE;
  wire cap_ack  = dly_done & ~dir_out & ~latch_in & pend_q;
  wire load_out = (st_q == S_IDLE) & go & dir_out;
  wire [15:0] ackw_cnt = (ackw_q == 8'h00) ? 16'h0000 : {8'h00, ackw_q - 8'h01};

  wire [31:0] din_ext;
  wire [31:0] cur_out_ext;
  generate
    if (DW < 32) begin : g_pad
      assign din_ext     = {{(32 - DW){1'b0}}, data_s2_q};
      assign cur_out_ext = {{(32 - DW){1'b0}}, data_out};
    end else begin : g_full
      assign din_ext     = data_s2_q[31:0];
      assign cur_out_ext = data_out[31:0];
    end
  endgenerate

  wire [2:0] wsel = reg_sel(aw_addr_q);
  wire [2:0] rsel = reg_sel(s_axi_araddr);
  wire       ar_hs = s_axi_arvalid & s_axi_arready;
  wire       rd_in = ar_hs & (rsel == 3'h4);
  wire       do_wr = aw_have_q & w_have_q & ~s_axi_bvalid;

  wire [31:0] ctrl_wr  = wmerge({25'h0000000, ctrl_q}, w_data_q, w_strb_q);
  wire [31:0] ackw_wr  = wmerge({24'h000000, ackw_q}, w_data_q, w_strb_q);
  wire [31:0] delay_wr = wmerge({16'h0000, delay_q}, w_data_q, w_strb_q);
  wire [31:0] out_wr   = wmerge(out_word_q, w_data_q, w_strb_q);

  // register file and axi4-lite slave
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= 2'h0;
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rresp   <= 2'h0;
      s_axi_rdata   <= 32'h0000_0000;
      aw_have_q     <= 1'b0;
      w_have_q      <= 1'b0;
      aw_addr_q     <= 8'h00;
      w_data_q      <= 32'h0000_0000;
      w_strb_q      <= 4'h0;
      ctrl_q        <= `EPHP_CTRL_RST;
      ackw_q        <= `EPHP_ACKW_RST;
      delay_q       <= `EPHP_DELAY_RST;
      out_word_q    <= 32'h0000_0000;
      out_pend_q    <= 1'b0;
      in_valid_q    <= 1'b0;
      in_word_q     <= 32'h0000_0000;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_addr_q     <= s_axi_awaddr;
        aw_have_q     <= 1'b1;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_data_q     <= s_axi_wdata;
        w_strb_q     <= s_axi_wstrb;
        w_have_q     <= 1'b1;
        s_axi_wready <= 1'b0;
      end
      if (do_wr) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (wsel == SEL_NONE) ? 2'h2 : 2'h0;
        case (wsel)
          3'h0:    ctrl_q     <= ctrl_wr[6:0];
          3'h1:    ackw_q     <= ackw_wr[7:0];
          3'h2:    delay_q    <= delay_wr[15:0];
          3'h3:    out_word_q <= out_wr;
          default: ;
        endcase
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        aw_have_q     <= 1'b0;
        w_have_q      <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
      // a word written in the cycle it is loaded stays pending: set wins
      out_pend_q <= (do_wr && wsel == 3'h3) | (out_pend_q & ~load_out);
      // a capture in the cycle of the clearing read wins over the read
      in_valid_q <= cap_lat | cap_ack | (in_valid_q & ~rd_in);
      if (cap_lat || cap_ack)
        in_word_q <= din_ext;
      if (ar_hs) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b1;
        s_axi_rresp   <= (rsel == SEL_NONE) ? 2'h2 : 2'h0;
        case (rsel)
          3'h0:    s_axi_rdata <= {25'h0, ctrl_q};
          3'h1:    s_axi_rdata <= {24'h0, ackw_q};
          3'h2:    s_axi_rdata <= {16'h0, delay_q};
          3'h3:    s_axi_rdata <= cur_out_ext;
          3'h4:    s_axi_rdata <= in_word_q;
          3'h5:    s_axi_rdata <= {27'h0, seen_q, req_act, ack_out ~^ ack_pol,
                                   out_pend_q, in_valid_q};
          default: s_axi_rdata <= 32'h0000_0000;
        endcase
      end
      if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid  <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

  // handshake engine: delay, acknowledge pulse, then the request edge of the word
  always @(posedge aclk) begin
    if (!aresetn) begin
      req_s1_q  <= 1'b0;
      req_s2_q  <= 1'b0;
      req_s3_q  <= 1'b0;
      data_s1_q <= {DW{1'b0}};
      data_s2_q <= {DW{1'b0}};
      st_q      <= S_IDLE;
      cnt_q     <= 16'h0000;
      seen_q    <= 1'b0;
      pend_q    <= 1'b0;
      got_q     <= 1'b0;
      ack_out   <= 1'b0;
      data_out  <= {DW{1'b0}};
      data_oe   <= 1'b0;
    end else begin
      // pins are asynchronous: two stages before any logic reads them
      req_s1_q  <= req_in;
      req_s2_q  <= req_s1_q;
      req_s3_q  <= req_s2_q;
      data_s1_q <= data_in;
      data_s2_q <= data_s1_q;
      data_oe   <= en & dir_out;
      if (!en) begin
        st_q    <= S_IDLE;
        cnt_q   <= 16'h0000;
        seen_q  <= 1'b0;
        pend_q  <= 1'b0;
        got_q   <= 1'b0;
        ack_out <= ~ack_pol;
      end else begin
        case (st_q)
          S_IDLE: begin
            // the first request edge only announces the peripheral, it carries no word
            if (req_ev && !dir_out)
              seen_q <= 1'b1;
            if (go) begin
              st_q  <= S_DELAY;
              cnt_q <= delay_q;
              got_q <= 1'b0;
              if (dir_out)
                data_out <= out_word_q[DW-1:0];
            end
          end
          S_DELAY: begin
            if (cnt_q == 16'h0000) begin
              st_q    <= S_ACK;
              ack_out <= ack_pol;
              cnt_q   <= lead ? LEAD_W_CYC - 16'h0001 : ackw_cnt;
              pend_q  <= 1'b0;
            end else begin
              cnt_q <= cnt_q - 16'h0001;
            end
          end
          S_ACK: begin
            if (take_ev) begin
              got_q  <= 1'b1;
              pend_q <= pend_set;
            end
            if (cnt_q != 16'h0000) begin
              cnt_q <= cnt_q - 16'h0001;
            end else if (!(lead && req_act)) begin
              ack_out <= ~ack_pol;
              st_q    <= (got_q || take_ev) ? st_after : S_WAIT;
              cnt_q   <= HOLD_CYC;
            end
          end
          S_WAIT: begin
            if (take_ev) begin
              got_q  <= 1'b1;
              pend_q <= pend_set;
              st_q   <= st_after;
              cnt_q  <= HOLD_CYC;
            end
          end
          S_HOLD: begin
            // output word stays put for the hold time after the request ends
            if (cnt_q == 16'h0000)
              st_q <= S_IDLE;
            else
              cnt_q <= cnt_q - 16'h0001;
          end
          default: st_q <= S_IDLE;
        endcase
      end
    end
  end
endmodule // ephp_port

//--- design/ephp_consts.vh
// constants for the edge pulse handshake port
`ifndef EPHP_CONSTS_VH
`define EPHP_CONSTS_VH

// register byte offsets
`define EPHP_CTRL_OFF      8'h00
`define EPHP_ACKW_OFF      8'h04
`define EPHP_DELAY_OFF     8'h08
`define EPHP_OUT_OFF       8'h0C
`define EPHP_IN_OFF        8'h10
`define EPHP_STAT_OFF      8'h14

// control field positions
`define EPHP_CTRL_EN       0
`define EPHP_CTRL_DIR      1
`define EPHP_CTRL_LEAD     2
`define EPHP_CTRL_LATIN    3
`define EPHP_CTRL_LATOUT   4
`define EPHP_CTRL_REQPOL   5
`define EPHP_CTRL_ACKPOL   6
`define EPHP_CTRL_RST      7'h68

// status field positions
`define EPHP_STAT_INVAL    0
`define EPHP_STAT_OUTPEND  1
`define EPHP_STAT_ACK      2
`define EPHP_STAT_REQ      3
`define EPHP_STAT_SEEN     4

// timing
`define EPHP_CLK_NS        100
`define EPHP_TAA_TRAIL_NS  225
`define EPHP_TAA_LEAD_NS   125
`define EPHP_TRDO_NS       50
`define EPHP_CEIL_CYC(ns)  (((ns) + `EPHP_CLK_NS - 1) / `EPHP_CLK_NS)
`define EPHP_ACKW_RST      8'h03
`define EPHP_DELAY_RST     16'h0000

`endif

//--- verification/ephp_port_assertions.sv
// assertions for the edge pulse handshake port
`timescale 1ns/1ps
module ephp_port_chk (
  input wire        aclk,
  input wire        aresetn,
  input wire [1:0]  s_axi_bresp,
  input wire        s_axi_bvalid,
  input wire        s_axi_bready,
  input wire [31:0] s_axi_rdata,
  input wire        s_axi_rvalid,
  input wire        s_axi_rready,
  input wire        req_in,
  input wire        ack_out,
  input wire        data_oe
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid)
    else $error("read response dropped");
  rdata_stable_a: assert property (s_axi_rvalid && !s_axi_rready |=> $stable(s_axi_rdata))
    else $error("read data moved while waiting");
  ack_idle_a: assert property ($rose(aresetn) |-> !ack_out)
    else $error("acknowledge active after reset");
  oe_idle_a: assert property ($rose(aresetn) |-> !data_oe)
    else $error("data driven after reset");
  ack_width_a: assert property ($rose(ack_out) |-> ack_out [*2])
    else $error("acknowledge pulse too short");
  ack_req_hold_a: assert property (ack_out && req_in |=> ack_out)
    else $error("acknowledge ended while request active");
  ack_end_a: assert property ($rose(ack_out) |-> ##[1:200] !ack_out)
    else $error("acknowledge pulse never ended");
endmodule // ephp_port_chk
bind ephp_port ephp_port_chk ephp_port_chk_inst (.aclk(aclk), .aresetn(aresetn),
  .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .req_in(req_in), .ack_out(ack_out), .data_oe(data_oe));

//--- verification/ephp_peer.sv
// peripheral model on the far side of the handshake port
`timescale 1ns/1ps
module ephp_peer (
  input  wire        aclk,
  input  wire        aresetn,
  input  wire        ack_out,
  input  wire        lead,
  input  wire        hold_long,
  input  wire        go,
  input  wire [31:0] word,
  output reg         req_in,
  output reg  [31:0] data_in
);
  reg [1:0] st_q;
  reg       ack_q;
  reg       first_q;
  reg       seen_q;
  reg       init_q;
  // sticky edge flag so a stalled bench never misses the readiness edge
  wire edge_w = lead ? (ack_out && !ack_q) : (!ack_out && ack_q);
  always @(posedge aclk) begin
    ack_q <= ack_out;
    if (!aresetn) begin
      {st_q, req_in, seen_q} <= 4'h0;
      first_q <= 1'h1;
      init_q <= 1'h0;
      data_in <= 32'h0;
    end else begin
      if (edge_w) seen_q <= 1'h1;
      case (st_q)
        2'h0: if (go && (first_q || seen_q)) begin
          data_in <= word;
          req_in <= 1'h1;
          init_q <= first_q;
          {first_q, seen_q} <= 2'h0;
          st_q <= 2'h1;
        end
        // in leading mode only the opening readiness request is held until acknowledge shows
        2'h1: if (!lead || !init_q || ack_out) begin
          req_in <= 1'h0;
          st_q <= hold_long ? 2'h2 : 2'h3;
        end
        2'h2: if (ack_out && !ack_q) st_q <= 2'h3;
        // released data shows the inverse from the next state on; with hold_long the word stays until acknowledge rises
        default: begin
          data_in <= ~data_in;
          st_q <= 2'h0;
        end
      endcase
    end
  end
endmodule // ephp_peer

//--- verification/tb_top.sv
// self-checking bench for the edge pulse handshake port
`timescale 1ns/1ps
`include "ephp_consts.vh"
module tb_top;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, go, lead, hl;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, word, seed;
  logic [63:0] e;
  logic [63:0] exp_q[$];
  wire         awready, wready, bvalid, arready, rvalid, req, ack, oe;
  wire [1:0]   bresp, rresp;
  wire [31:0]  rdata, din, dout;
  int          fail_count, checked, i, m;
  ephp_port ephp_port_inst (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .req_in(req),
    .data_in(din), .ack_out(ack), .data_out(dout), .data_oe(oe));
  ephp_peer ephp_peer_inst (.aclk(aclk), .aresetn(aresetn), .ack_out(ack), .lead(lead),
    .hold_long(hl), .go(go), .word(word), .req_in(req), .data_in(din));
  initial begin
    aclk = 0;
    forever #50 aclk = ~aclk;
  end
  task automatic print_verdict;
    $display("mismatches %0d, checks %0d", fail_count, checked);
    if (fail_count == 0 && checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic check(input logic [31:0] s, input logic [31:0] x);
    checked++;
    if (s !== x) begin
      fail_count++;
      $display("ERROR %0t: saw %h expected %h", $time, s, x);
    end
  endtask
  task automatic hang(input int n);
    if (n >= 300) begin
      fail_count++;
      $display("ERROR %0t: wait ran out", $time);
      print_verdict();
    end
  endtask
  function automatic logic [31:0] nxt;
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic do_rst;
    aresetn <= 0;
    repeat (5) @(posedge aclk);
    aresetn <= 1;
  endtask
  task automatic axw(input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge aclk);
    {awaddr, wdata, awvalid, wvalid, bready} <= {a, d, 3'h7};
    for (n = 0; n < 300; n++) begin
      @(posedge aclk);
      if (awready) awvalid <= 0;
      if (wready) wvalid <= 0;
      if (bvalid) break;
    end
    bready <= 0;
    hang(n);
  endtask
  task automatic axr(input logic [7:0] a, input logic [31:0] d, input logic [31:0] k);
    int n;
    exp_q.push_back({k, d});
    @(posedge aclk);
    {araddr, arvalid, rready} <= {a, 2'h3};
    for (n = 0; n < 300; n++) begin
      @(posedge aclk);
      if (arready) arvalid <= 0;
      if (rvalid) break;
    end
    rready <= 0;
    hang(n);
  endtask
  task automatic wt(input bit v);
    int n;
    @(posedge aclk);
    for (n = 0; n < 300 && ((din === word) != v); n++) @(posedge aclk);
    hang(n);
  endtask
  // the reader notes each expectation; this process compares it when data returns
  always @(posedge aclk) begin
    if (rvalid === 1'b1 && rready) begin
      e = exp_q.pop_front();
      check(rdata & e[63:32], e[31:0] & e[63:32]);
    end
  end
  initial begin
    {awvalid, wvalid, bready, arvalid, rready, go, lead, hl} = 8'h00;
    {awaddr, araddr, wdata, word} = 0;
    seed = 32'h2851;
    aresetn = 0;
    do_rst();
    axr(`EPHP_CTRL_OFF, 32'h68, '1);
    axr(`EPHP_ACKW_OFF, 32'h3, '1);
    axr(`EPHP_DELAY_OFF, 32'h0, '1);
    axr(8'h20, 32'h0, 32'h0);
    // modes: trailing latched, trailing unlatched with long hold, leading latched
    for (m = 0; m < 3; m++) begin
      do_rst();
      lead <= (m == 2);
      hl <= (m == 1);
      axw(`EPHP_DELAY_OFF, m);
      axr(`EPHP_DELAY_OFF, m, '1);
      axw(`EPHP_CTRL_OFF, m == 0 ? 32'h69 : m == 1 ? 32'h61 : 32'h6D);
      for (i = 0; i < 4; i++) begin
        word <= nxt();
        go <= 1;
        wt(1);
        go <= 0;
        wt(0);
        if (i > 0) begin
          repeat (4) @(posedge aclk);
          axr(`EPHP_IN_OFF, word, '1);
        end
      end
    end
    word <= nxt();
    {lead, hl} <= 2'h0;
    do_rst();
    axw(`EPHP_OUT_OFF, word);
    axw(`EPHP_CTRL_OFF, 32'h6B);
    go <= 1;
    wt(1);
    go <= 0;
    wt(0);
    check(dout, word);
    check(oe, 32'h1);
    print_verdict();
  end
endmodule // tb_top
